// ===== hw/lrap_param_mem.v
// Small parameter store: one write port, one read port with registered read data.
// Assumes both ports run on the same clock; a read and write of one word return the old value.
`timescale 1ns/1ps
`include "lrap_regs.vh"

module lrap_param_mem
(
  input wire clk,
  input wire we,
  input wire [3:0] waddr,
  input wire [7:0] wdata,
  input wire [3:0] raddr,
  output reg [7:0] rdata
);

  reg [7:0] mem [0:`LRAP_MEM_WORDS-1];

  // Plain register array; no reset, so software loads it before the master asks.
  always @(posedge clk)
  begin
    if (we)
      mem[waddr] <= wdata;
    rdata <= mem[raddr];
  end

endmodule // lrap_param_mem

// ===== hw/lrap_regs.vh
// Constants for the read-actual-parameters responder: frame codes, bus offsets, field bits.
// Assumes a frame-level LIN link layer outside that delivers identifiers and data bytes.
`ifndef LRAP_REGS_VH
`define LRAP_REGS_VH

// Frame identifiers as they arrive from the link layer.
`define LRAP_ID_MASTER_REQ 8'h3C
`define LRAP_ID_SLAVE_RESP 8'h7D

// Request byte contents.
`define LRAP_APP_CMD 8'h80
`define LRAP_CMD_PART1 7'h02
`define LRAP_CMD_PART2 7'h03
`define LRAP_FILLER 8'hFF
`define LRAP_CSUM_GOOD 8'hFF
`define LRAP_DATA_BYTES 4'h8

// Parameter memory: 12 bytes, colours then coefficients in response order.
`define LRAP_MEM_WORDS 12
`define LRAP_PART2_BASE 4'h6
`define LRAP_IDX_LAST 4'hB

// Avalon byte offsets of the parameter words (word n at 4*n) and of the extra words.
`define LRAP_OFS_PARAM_LAST 8'h2C
`define LRAP_OFS_CONTROL 8'h40
`define LRAP_OFS_STATUS 8'h44

// Control word fields.
`define LRAP_CTL_TRANSITION 0
`define LRAP_CTL_CAL_EN 1
`define LRAP_CTL_MOD_FREQ 2
`define LRAP_CTL_THERMAL 3
`define LRAP_CTL_GROUP_LSB 4
`define LRAP_CTL_NODE_LSB 8
`define LRAP_CTL_RESET 14'h0000

// Current level when no thermal reduction applies.
`define LRAP_LEVEL_FULL 4'hF

`endif

// ===== hw/lrap_responder.v
// Overview of operation
// - Current parameters are reported over two separate request and response pairs.
// - Requests come in master-request frames; answers go in the next slave-response frame.
// - Third byte is 11 plus node address; act only on match; echo it first.
// - Classic checksum over data bytes ends every frame; received ones are verified.
// - Responses go out in frames with identifier 0x7D.
// - Diagonal coefficients in part one bytes 5-7; off-diagonal six in part two.
// - Part one byte eight bit 7 reports whether transitions are enabled.
// - Part two byte eight: calibration enable in bit 7, modulation frequency bit 6.
// - Part two byte eight: one in bit 5, thermal enable bit 4, group address low.
// - With thermal control on, current drops in fifteen 6.25 percent steps.
//
// Holds the read-actual-parameters responder with its Avalon-MM register slave.
// Assumes a frame-level link layer: header pulses, received bytes, and a tx byte handshake.
`timescale 1ns/1ps
`include "lrap_regs.vh"

module lrap_responder
(
  input wire sys_clk,
  input wire rstn,
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire lin_hdr_valid,
  input wire [7:0] lin_hdr_id,
  input wire lin_rx_valid,
  input wire [7:0] lin_rx_byte,
  output reg lin_tx_valid,
  output reg [7:0] lin_tx_byte,
  input wire lin_tx_ready,
  input wire [3:0] thermal_reduction_level,
  output reg [3:0] led_current_level
);

  localparam ST_IDLE = 3'd0;
  localparam ST_RX = 3'd1;
  localparam ST_FETCH = 3'd2;
  localparam ST_LOAD = 3'd3;
  localparam ST_SEND = 3'd4;

  reg rst_meta;
  reg rst_sync;
  reg [2:0] state;
  reg [3:0] byte_idx;
  reg [7:0] sum;
  reg req_ok;
  reg req_part2;
  reg resp_pending;
  reg resp_part2;
  reg [13:0] control;
  reg av_stage;
  wire transition_enable;
  wire cal_en;
  wire modulation_frequency_select;
  wire thermal_current_limit_enable;
  wire [3:0] group_address;
  wire [5:0] node_address;
  wire [7:0] addr_byte;
  wire [3:0] resp_raddr;
  wire [3:0] av_index;
  wire av_param;
  wire av_free;
  wire mem_we;
  wire [3:0] mem_raddr;
  wire [7:0] mem_rdata;
  reg [7:0] next_tx_byte;
  reg next_req_ok;

  // Classic checksum step: add with the carry wrapped back into bit 0.
  function [7:0] csum_add;
    input [7:0] a;
    input [7:0] b;
    reg [8:0] s;
    begin
      s = {1'b0, a} + {1'b0, b};
      csum_add = s[7:0] + {7'h00, s[8]};
    end
  endfunction

  // Reset is released through two flops so every process leaves reset on the same edge.
  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  assign transition_enable = control[`LRAP_CTL_TRANSITION];
  assign cal_en = control[`LRAP_CTL_CAL_EN];
  assign modulation_frequency_select = control[`LRAP_CTL_MOD_FREQ];
  assign thermal_current_limit_enable = control[`LRAP_CTL_THERMAL];
  assign group_address = control[`LRAP_CTL_GROUP_LSB+3:`LRAP_CTL_GROUP_LSB];
  assign node_address = control[`LRAP_CTL_NODE_LSB+5:`LRAP_CTL_NODE_LSB];
  assign addr_byte = {2'b11, node_address};

  // Part two starts six words further on, so one counter walks both layouts.
  assign resp_raddr = (resp_part2 ? `LRAP_PART2_BASE : 4'h0) + byte_idx - 4'h1;
  assign av_index = avs_address[5:2];
  assign av_param = (avs_address <= `LRAP_OFS_PARAM_LAST) && (avs_address[1:0] == 2'b00);
  // The responder owns the read port while fetching; bus reads simply wait a cycle.
  assign av_free = (state != ST_FETCH);
  assign mem_raddr = av_free ? av_index : resp_raddr;
  assign mem_we = avs_write && avs_waitrequest && av_param && avs_byteenable[0];

  lrap_param_mem u_mem
  (
    .clk(sys_clk),
    .we(mem_we),
    .waddr(av_index),
    .wdata(avs_writedata[7:0]),
    .raddr(mem_raddr),
    .rdata(mem_rdata)
  );

  // Per-byte request check; the running verdict falls on the first wrong byte.
  always @*
  begin
    next_req_ok = req_ok;
    if (byte_idx == 4'h0)
      next_req_ok = (lin_rx_byte == `LRAP_APP_CMD);
    else if (byte_idx == 4'h1)
    begin
      next_req_ok = req_ok && lin_rx_byte[7] &&
        ((lin_rx_byte[6:0] == `LRAP_CMD_PART1) || (lin_rx_byte[6:0] == `LRAP_CMD_PART2));
    end
    else if (byte_idx == 4'h2)
      next_req_ok = req_ok && (lin_rx_byte == addr_byte);
    else if (byte_idx < `LRAP_DATA_BYTES)
      next_req_ok = req_ok && (lin_rx_byte == `LRAP_FILLER);
    else
      next_req_ok = req_ok && (csum_add(sum, lin_rx_byte) == `LRAP_CSUM_GOOD);
  end

  // Response byte selection: address echo, six stored bytes, flag byte, checksum.
  always @*
  begin
    if (byte_idx == 4'h0)
      next_tx_byte = addr_byte;
    else if (byte_idx < 4'h7)
      next_tx_byte = mem_rdata;
    else if (byte_idx == 4'h7 && !resp_part2)
      next_tx_byte = {transition_enable, 7'h7F};
    else if (byte_idx == 4'h7)
      next_tx_byte = {cal_en, modulation_frequency_select, 1'b1,
        thermal_current_limit_enable, group_address};
    else
      next_tx_byte = ~sum;
  end

  // Frame handler. A new header always wins, so a stale response never leaks out.
  always @(posedge sys_clk or negedge rst_sync)
  begin
    if (!rst_sync)
    begin
      state <= ST_IDLE;
      byte_idx <= 4'h0;
      sum <= 8'h00;
      req_ok <= 1'b0;
      req_part2 <= 1'b0;
      resp_pending <= 1'b0;
      resp_part2 <= 1'b0;
      lin_tx_valid <= 1'b0;
      lin_tx_byte <= 8'h00;
    end
    else if (lin_hdr_valid)
    begin
      lin_tx_valid <= 1'b0;
      byte_idx <= 4'h0;
      sum <= 8'h00;
      req_ok <= 1'b0;
      // Any header consumes the pending answer; only a 0x7D header uses it.
      resp_pending <= 1'b0;
      if (lin_hdr_id == `LRAP_ID_MASTER_REQ)
        state <= ST_RX;
      else if (lin_hdr_id == `LRAP_ID_SLAVE_RESP && resp_pending)
        state <= ST_FETCH;
      else
        state <= ST_IDLE;
    end
    else
    begin
      case (state)
        ST_RX:
        begin
          if (lin_rx_valid)
          begin
            req_ok <= next_req_ok;
            sum <= csum_add(sum, lin_rx_byte);
            byte_idx <= byte_idx + 4'h1;
            if (byte_idx == 4'h1)
              req_part2 <= (lin_rx_byte[6:0] == `LRAP_CMD_PART2);
            if (byte_idx == `LRAP_DATA_BYTES)
            begin
              // Only a fully valid request arms the next slave response.
              resp_pending <= next_req_ok;
              resp_part2 <= req_part2;
              byte_idx <= 4'h0;
              state <= ST_IDLE;
            end
          end
        end
        ST_FETCH:
          state <= ST_LOAD;
        ST_LOAD:
        begin
          lin_tx_byte <= next_tx_byte;
          lin_tx_valid <= 1'b1;
          state <= ST_SEND;
        end
        ST_SEND:
        begin
          if (lin_tx_ready)
          begin
            lin_tx_valid <= 1'b0;
            byte_idx <= byte_idx + 4'h1;
            if (byte_idx == `LRAP_DATA_BYTES)
              state <= ST_IDLE;
            else
            begin
              sum <= csum_add(sum, lin_tx_byte);
              state <= ST_FETCH;
            end
          end
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // Avalon slave: writes and register reads answer one edge after being taken,
  // parameter reads one edge later because the memory read data is registered.
  always @(posedge sys_clk or negedge rst_sync)
  begin
    if (!rst_sync)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
      av_stage <= 1'b0;
      control <= `LRAP_CTL_RESET;
    end
    else if (!avs_waitrequest)
      avs_waitrequest <= 1'b1;
    else if (av_stage)
    begin
      avs_readdata <= {24'h000000, mem_rdata};
      av_stage <= 1'b0;
      avs_waitrequest <= 1'b0;
    end
    else if (avs_write)
    begin
      if (avs_address == `LRAP_OFS_CONTROL)
      begin
        if (avs_byteenable[0])
          control[7:0] <= avs_writedata[7:0];
        if (avs_byteenable[1])
          control[13:8] <= avs_writedata[13:8];
      end
      avs_waitrequest <= 1'b0;
    end
    else if (avs_read)
    begin
      if (av_param)
      begin
        if (av_free)
          av_stage <= 1'b1;
      end
      else if (avs_address == `LRAP_OFS_CONTROL)
      begin
        avs_readdata <= {18'h00000, control};
        avs_waitrequest <= 1'b0;
      end
      else if (avs_address == `LRAP_OFS_STATUS)
      begin
        avs_readdata <= {26'h0000000, resp_part2, resp_pending, thermal_reduction_level};
        avs_waitrequest <= 1'b0;
      end
      else
      begin
        avs_readdata <= 32'h00000000;
        avs_waitrequest <= 1'b0;
      end
    end
  end

  // Level 15 is full current; each step below it removes 6.25 percent of nominal.
  always @(posedge sys_clk or negedge rst_sync)
  begin
    if (!rst_sync)
      led_current_level <= `LRAP_LEVEL_FULL;
    else if (thermal_current_limit_enable)
      led_current_level <= thermal_reduction_level;
    else
      led_current_level <= `LRAP_LEVEL_FULL;
  end

endmodule // lrap_responder

// ===== tb/lin_read_actual_params_tb_top.sv
// Self-checking bench: loads parameters over the bus, then reads them back in frames.
// Assumes lrap_responder and the master model; checks are counted and reported once.
`timescale 1ns/1ps
`include "lrap_regs.vh"
module lin_read_actual_params_tb_top;
  reg sys_clk, rstn, avs_read, avs_write, slow;
  reg [7:0] avs_address;
  reg [31:0] avs_writedata, seed, q;
  reg [3:0] thermal_reduction_level;
  reg [3:0] avs_byteenable;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, hv, rv, tv, tr;
  wire [7:0] hid, rb, txb;
  wire [3:0] led_current_level;
  integer n_fail, cmp_count, cyc, i, r, n;
  reg [7:0] prm [0:11];
  reg [13:0] ctl;
  reg [63:0] d;
  reg [71:0] got;
  lrap_responder i_lrap_responder (.sys_clk(sys_clk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .lin_hdr_valid(hv), .lin_hdr_id(hid), .lin_rx_valid(rv), .lin_rx_byte(rb),
    .lin_tx_valid(tv), .lin_tx_byte(txb), .lin_tx_ready(tr),
    .thermal_reduction_level(thermal_reduction_level), .led_current_level(led_current_level));
  lrap_lin_master i_lrap_lin_master (.sys_clk(sys_clk), .slow(slow), .lin_tx_valid(tv),
    .lin_tx_byte(txb), .lin_hdr_valid(hv), .lin_hdr_id(hid), .lin_rx_valid(rv),
    .lin_rx_byte(rb), .lin_tx_ready(tr));
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  function [31:0] lf(input [31:0] s);
    lf = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Expected response of one part, built from the values that were written.
  function [71:0] exp_rsp(input integer b);
    reg [7:0] f;
    begin
      f = b ? {ctl[1], ctl[2], 1'b1, ctl[3], ctl[7:4]} : {ctl[0], 7'h7F};
      d = {2'b11, ctl[13:8], prm[b], prm[b+1], prm[b+2], prm[b+3], prm[b+4], prm[b+5], f};
      exp_rsp = {d, i_lrap_lin_master.csum(d)};
    end
  endfunction
  task close_out;
    begin
      if (n_fail == 0 && cmp_count > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task ck(input [71:0] g, input [71:0] e);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e)
      begin
        n_fail = n_fail + 1;
        $display("[FAIL] %0t got %h expected %h", $time, g, e);
      end
    end
  endtask
  // One bus cycle, held until the slave answers; read data lands in q.
  // It sets no limit of its own, so only the cycle ceiling can end a hung answer.
  task av(input w, input [7:0] a, input [31:0] wd);
    begin
      @(posedge sys_clk);
      avs_read <= ~w;
      avs_write <= w;
      avs_address <= a;
      avs_writedata <= wd;
      @(posedge sys_clk);
      while (avs_waitrequest !== 1'b0)
        @(posedge sys_clk);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
    end
  endtask
  always @(posedge sys_clk)
  begin
    cyc = cyc + 1;
    if (cyc == 40000)
    begin
      n_fail = n_fail + 1;
      $display("[FAIL] %0t cycle ceiling reached", $time);
      close_out;
    end
  end
  initial
  begin
    {rstn, avs_read, avs_write, slow, avs_address, avs_writedata} = 0;
    thermal_reduction_level = 4'h0;
    avs_byteenable = 4'hF;
    seed = 32'd78240;
    {n_fail, cmp_count, cyc} = 0;
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    for (i = 0; i < 12; i = i + 1)
    begin
      seed = lf(seed);
      prm[i] = seed[7:0];
      av(1'b1, {i[5:0], 2'b00}, {24'h0, prm[i]});
      av(1'b0, {i[5:0], 2'b00}, 32'h0);
      ck(q[7:0], prm[i]);
    end
    // A parameter write without its byte lane must leave the stored value alone.
    avs_byteenable <= 4'h0;
    av(1'b1, 8'h00, {24'h0, ~prm[0]});
    avs_byteenable <= 4'hF;
    av(1'b0, 8'h00, 32'h0);
    ck(q[7:0], prm[0]);
    av(1'b0, 8'h80, 32'h0);
    ck(q, 32'h0);
    // Each round: fresh settings, both parts, then one broken or stale request.
    for (r = 0; r < 7; r = r + 1)
    begin
      seed = lf(seed);
      ctl = seed[13:0];
      thermal_reduction_level <= seed[19:16];
      av(1'b1, `LRAP_OFS_CONTROL, {18'h0, ctl});
      av(1'b0, `LRAP_OFS_CONTROL, 32'h0);
      ck(q, {18'h0, ctl});
      for (i = 0; i < 2; i = i + 1)
      begin
        slow <= seed[20+i];
        i_lrap_lin_master.send(d_req(i), i_lrap_lin_master.csum(d_req(i)));
        av(1'b0, `LRAP_OFS_STATUS, 32'h0);
        ck(q, {26'h0, i[0], 1'b1, thermal_reduction_level});
        i_lrap_lin_master.resp(got, n);
        ck(got, exp_rsp(i * 6));
      end
      ck(led_current_level, ctl[3] ? thermal_reduction_level : 4'hF);
      d = d_req(r & 1);
      case (r)
        0: d[40] = ~d[40];
        2: d[63:56] = 8'h81;
        3: d[54:48] = 7'h04;
        4: d[55] = 1'b0;
        5: d[7:0] = 8'hFE;
        default: ;
      endcase
      i_lrap_lin_master.send(d, i_lrap_lin_master.csum(d) + (r == 1));
      if (r == 6)
        i_lrap_lin_master.hdr(`LRAP_ID_MASTER_REQ);
      i_lrap_lin_master.resp(got, n);
      ck(n, 0);
    end
    close_out;
  end
  function [63:0] d_req(input integer p);
    d_req = {8'h80, 1'b1, p ? 7'h03 : 7'h02, 2'b11, ctl[13:8], 40'hFFFFFFFFFF};
  endfunction
endmodule // lin_read_actual_params_tb_top

// ===== tb/lrap_lin_master.sv
// Frame-level model of the bus master: sends requests and collects responses.
// Assumes the responder's byte handshake; slow makes it stall every other cycle.
`timescale 1ns/1ps
`include "lrap_regs.vh"
module lrap_lin_master
(
  input wire sys_clk,
  input wire slow,
  input wire lin_tx_valid,
  input wire [7:0] lin_tx_byte,
  output reg lin_hdr_valid,
  output reg [7:0] lin_hdr_id,
  output reg lin_rx_valid,
  output reg [7:0] lin_rx_byte,
  output reg lin_tx_ready
);
  initial
  begin
    lin_hdr_valid = 1'b0;
    lin_hdr_id = 8'h00;
    lin_rx_valid = 1'b0;
    lin_rx_byte = 8'h00;
    lin_tx_ready = 1'b1;
  end
  // Classic checksum: inverted sum of data bytes, carries folded back.
  function [7:0] csum(input [63:0] d);
    reg [8:0] s;
    integer i;
    begin
      s = 9'h000;
      for (i = 0; i < 8; i = i + 1)
        s = s[7:0] + s[8] + d[i*8 +: 8];
      csum = ~(s[7:0] + s[8]);
    end
  endfunction
  // Idle lines show the inverse of their last value, so stale data never matches.
  task hdr(input [7:0] id);
    begin
      @(posedge sys_clk);
      lin_hdr_valid <= 1'b1;
      lin_hdr_id <= id;
      @(posedge sys_clk);
      lin_hdr_valid <= 1'b0;
      lin_hdr_id <= ~id;
    end
  endtask
  task send(input [63:0] d, input [7:0] ck);
    integer i;
    begin
      hdr(`LRAP_ID_MASTER_REQ);
      for (i = 0; i < 9; i = i + 1)
      begin
        @(posedge sys_clk);
        lin_rx_valid <= 1'b1;
        lin_rx_byte <= (i < 8) ? d[63-8*i -: 8] : ck;
        @(posedge sys_clk);
        lin_rx_valid <= 1'b0;
        lin_rx_byte <= ~lin_rx_byte;
      end
    end
  endtask
  task resp(output [71:0] got, output integer n);
    integer k;
    begin
      got = 72'h0;
      n = 0;
      hdr(`LRAP_ID_SLAVE_RESP);
      for (k = 0; k < 80 && n < 9; k = k + 1)
      begin
        @(posedge sys_clk);
        if (lin_tx_valid && lin_tx_ready)
        begin
          got = {got[63:0], lin_tx_byte};
          n = n + 1;
        end
        lin_tx_ready <= slow ? ~lin_tx_ready : 1'b1;
      end
    end
  endtask
endmodule // lrap_lin_master

// ===== tb/lrap_monitor.sv
// Checker on the responder ports: bus answer timing, response pacing, current level.
// Assumes it is bound to lrap_responder; rstn is the raw low-active reset.
`timescale 1ns/1ps
`include "lrap_regs.vh"
module lrap_monitor
(
  input wire sys_clk,
  input wire rstn,
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  input wire lin_hdr_valid,
  input wire [7:0] lin_hdr_id,
  input wire lin_tx_valid,
  input wire [7:0] lin_tx_byte,
  input wire lin_tx_ready,
  input wire [3:0] thermal_reduction_level,
  input wire [3:0] led_current_level
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // Plain terms, so that past values look at signals only.
  wire acc = lin_tx_valid & lin_tx_ready;
  wire hdr_rsp = lin_hdr_valid & (lin_hdr_id == `LRAP_ID_SLAVE_RESP);
  chk_wait_pulse:
    assert property (!avs_waitrequest |=> avs_waitrequest) else $error("long answer");
  chk_wait_idle:
    assert property (!avs_read && !avs_write |=> avs_waitrequest) else $error("idle answer");
  chk_tx_hold:
    assert property (lin_tx_valid && !lin_tx_ready && !lin_hdr_valid
      |=> lin_tx_valid && $stable(lin_tx_byte)) else $error("byte not held");
  chk_tx_gap:
    assert property (acc |=> !lin_tx_valid [*2]) else $error("byte too soon");
  chk_hdr_quiet:
    assert property (lin_hdr_valid |=> !lin_tx_valid) else $error("header kept byte");
  chk_other_silent:
    assert property (lin_hdr_valid && !hdr_rsp |=> !lin_tx_valid [*4]) else $error("talked");
  chk_tx_cause:
    assert property ($rose(lin_tx_valid) |-> $past(hdr_rsp, 2) || $past(hdr_rsp, 3)
      || $past(acc, 3) || $past(acc, 4)) else $error("byte without cause");
  chk_echo_addr:
    assert property ($rose(lin_tx_valid) && ($past(hdr_rsp, 2) || $past(hdr_rsp, 3))
      |-> lin_tx_byte[7:6] == 2'b11) else $error("bad first byte");
  chk_level_src:
    assert property (led_current_level == 4'hF
      || led_current_level == $past(thermal_reduction_level)) else $error("bad level");
  cover property (hdr_rsp ##[2:3] lin_tx_valid);
  cover property (avs_read && !avs_waitrequest);
  cover property (led_current_level != 4'hF);
endmodule // lrap_monitor
bind lrap_responder lrap_monitor i_lrap_monitor (.sys_clk, .rstn, .avs_read, .avs_write,
  .avs_waitrequest, .lin_hdr_valid, .lin_hdr_id, .lin_tx_valid, .lin_tx_byte, .lin_tx_ready,
  .thermal_reduction_level, .led_current_level);
